/* shared/sfcd_pkg.sv */
// Function
// - opcode arrives on the serial input line; later phases use one, two or four lines
// - host may end any data-out phase after any bit; output stops cleanly
// - modifying commands execute only if select rises after a multiple of eight clocks
// - array accesses are ignored while a modify cycle runs
// - running modify cycles are never disturbed, except by the pause command
// - pause 75h stops program or erase, not otp, whole wipe or register writes
// - resume 7Ah continues a paused cycle, no address, no data
// - status 05h and flag status 70h fetches are accepted while busy
// - plain fetch 03h no dummy; fast fetch 0Bh eight dummy clocks; both stream
// - fast, multi-line and otp fetches use a configurable dummy count
// - discovery-table fetch 5Ah: address, fixed eight dummy clocks, streaming data
// - 3Bh, BBh, 6Bh use eight dummy clocks; EBh uses ten; all take address
// - identity fetch 9Eh/9Fh: no address, no dummy, up to twenty bytes
// - otp fetch 4Bh and otp write 42h move one to sixty-five bytes
// - write latch set 06h and clear 04h carry nothing after the opcode
// - page writes 02h, A2h, D2h, 32h, 12h take address and 1 to 256 bytes
// - block wipes 20h and D8h take address; whole wipe C7h none; no data
// - status write 01h one byte; flag clear 50h nothing; status fetches stream
// - lock fetch E8h and lock write E5h take address; write carries one byte
// - nv config fetch B5h and write B1h move exactly two bytes
// - config 85h/81h and enhanced 65h/61h: writes one byte, fetches stream
// - everything travels msb first, input sampled on rising serial clock
// - output bits change on falling serial clock
package sfcd_pkg;
  localparam logic [7:0] OP_IDENTITY_FETCH = 8'h9E;
  localparam logic [7:0] OP_PLAIN_FETCH = 8'h03;
  localparam logic [7:0] OP_FAST_FETCH = 8'h0B;
  localparam logic [7:0] OP_DISCOVERY_TABLE_FETCH = 8'h5A;
  localparam logic [7:0] OP_DUAL_OUT_FETCH = 8'h3B;
  localparam logic [7:0] OP_DUAL_IO_FETCH = 8'hBB;
  localparam logic [7:0] OP_QUAD_OUT_FETCH = 8'h6B;
  localparam logic [7:0] OP_QUAD_IO_FETCH = 8'hEB;
  localparam logic [7:0] OP_OTP_FETCH = 8'h4B;
  localparam logic [7:0] OP_WRITE_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_WRITE_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] OP_SINGLE_PAGE_WRITE = 8'h02;
  localparam logic [7:0] OP_DUAL_IN_PAGE_WRITE = 8'hA2;
  localparam logic [7:0] OP_DUAL_IN_EXT_PAGE_WRITE = 8'hD2;
  localparam logic [7:0] OP_QUAD_IN_PAGE_WRITE = 8'h32;
  localparam logic [7:0] OP_QUAD_IN_EXT_PAGE_WRITE = 8'h12;
  localparam logic [7:0] OP_OTP_WRITE = 8'h42;
  localparam logic [7:0] OP_BLOCK4K_WIPE = 8'h20;
  localparam logic [7:0] OP_BLOCK64K_WIPE = 8'hD8;
  localparam logic [7:0] OP_WHOLE_ARRAY_WIPE = 8'hC7;
  localparam logic [7:0] OP_MODIFY_RESUME = 8'h7A;
  localparam logic [7:0] OP_MODIFY_PAUSE = 8'h75;
  localparam logic [7:0] OP_STATUS_FETCH = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_LOCK_FETCH = 8'hE8;
  localparam logic [7:0] OP_LOCK_WRITE = 8'hE5;
  localparam logic [7:0] OP_FLAG_STATUS_FETCH = 8'h70;
  localparam logic [7:0] OP_FLAG_STATUS_CLEAR = 8'h50;
  localparam logic [7:0] OP_NV_CONFIG_FETCH = 8'hB5;
  localparam logic [7:0] OP_NV_CONFIG_WRITE = 8'hB1;
  localparam logic [7:0] OP_VOL_CONFIG_FETCH = 8'h85;
  localparam logic [7:0] OP_VOL_CONFIG_WRITE = 8'h81;
  localparam logic [7:0] OP_ENH_CONFIG_FETCH = 8'h65;
  localparam logic [7:0] OP_ENH_CONFIG_WRITE = 8'h61;

  localparam int BYTE_BITS = 8;
  localparam int ADDR_BITS = 24;
  localparam logic [2:0] LINES_1 = 3'd1;
  localparam logic [2:0] LINES_2 = 3'd2;
  localparam logic [2:0] LINES_4 = 3'd4;
  localparam logic [4:0] DUMMY_DEFAULT = 5'd8;
  localparam logic [4:0] DUMMY_QUAD_IO_DEFAULT = 5'd10;
  localparam logic [4:0] DUMMY_DISCOVERY = 5'd8;
  localparam logic [3:0] DUMMY_CFG_USE_DEFAULT = 4'h0;
  localparam logic [8:0] IDENTITY_BYTES = 9'd20;
  localparam logic [8:0] OTP_BYTES = 9'd65;
  localparam logic [8:0] PAGE_BYTES = 9'd256;
  localparam logic [8:0] NV_CONFIG_BYTES = 9'd2;
  localparam logic [8:0] REG_WRITE_BYTES = 9'd1;
  localparam logic [8:0] COUNT_SAT = 9'h1FF;
  localparam int SYNC_SCLK = 0;
  localparam int SYNC_CS = 1;
  localparam int SYNC_IO = 2;

  typedef enum logic [1:0] {DMY_NONE, DMY_CFG, DMY_FIXED} sfcd_dummy_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_OPC, ST_ADDR, ST_DUMMY, ST_DIN, ST_DOUT, ST_HOLD, ST_IGNORE
  } sfcd_phase_t;

  typedef struct packed {
    logic known;
    logic has_addr;
    logic [2:0] addr_lines;
    sfcd_dummy_t dummy;
    logic [4:0] dummy_def;
    logic din;
    logic dout;
    logic [2:0] data_lines;
    logic exec;
    logic array;
    logic [8:0] cnt_min;
    logic [8:0] cnt_max;
  } sfcd_attr_t;

  typedef struct packed {
    logic [5:0] m;
    logic [5:0] s;
  } sfcd_sync_t;
  localparam sfcd_sync_t SYNC_RESET = '{m: 6'h02, s: 6'h02};

  typedef struct packed {
    logic [7:0] sr;
    logic [3:0] dout;
    logic [3:0] oe_n;
    logic [2:0] lines;
    logic [3:0] left;
  } sfcd_shift_t;
  localparam sfcd_shift_t SHIFT_RESET = '{
    sr: 8'h00, dout: 4'h0, oe_n: 4'hF, lines: 3'd1, left: 4'h0};

  function automatic logic [4:0] sfcd_last(input int bits, input logic [2:0] lines);
    int sh;
    sh = (lines == LINES_4) ? 2 : ((lines == LINES_2) ? 1 : 0);
    return 5'((bits >> sh) - 1);
  endfunction

  function automatic sfcd_attr_t sfcd_attr(input logic [7:0] op);
    sfcd_attr_t a;
    a = '0;
    a.addr_lines = LINES_1;
    a.data_lines = LINES_1;
    a.dummy_def = DUMMY_DEFAULT;
    if (op[7:1] == OP_IDENTITY_FETCH[7:1]) begin
      a.known = 1'b1;
      a.dout = 1'b1;
      a.array = 1'b1;
      a.cnt_max = IDENTITY_BYTES;
    end
    case (op)
      OP_PLAIN_FETCH: begin
        a.known = 1'b1;
        a.has_addr = 1'b1;
        a.dout = 1'b1;
        a.array = 1'b1;
      end
      OP_FAST_FETCH, OP_DUAL_OUT_FETCH, OP_DUAL_IO_FETCH, OP_QUAD_OUT_FETCH,
      OP_QUAD_IO_FETCH, OP_OTP_FETCH: begin
        a.known = 1'b1;
        a.has_addr = 1'b1;
        a.dummy = DMY_CFG;
        a.dout = 1'b1;
        a.array = 1'b1;
      end
      OP_DISCOVERY_TABLE_FETCH: begin
        a.known = 1'b1;
        a.has_addr = 1'b1;
        a.dummy = DMY_FIXED;
        a.dout = 1'b1;
        a.array = 1'b1;
      end
      OP_SINGLE_PAGE_WRITE, OP_DUAL_IN_PAGE_WRITE, OP_DUAL_IN_EXT_PAGE_WRITE,
      OP_QUAD_IN_PAGE_WRITE, OP_QUAD_IN_EXT_PAGE_WRITE, OP_OTP_WRITE: begin
        a.known = 1'b1;
        a.has_addr = 1'b1;
        a.din = 1'b1;
        a.exec = 1'b1;
        a.array = 1'b1;
        a.cnt_min = REG_WRITE_BYTES;
        a.cnt_max = PAGE_BYTES;
      end
      OP_BLOCK4K_WIPE, OP_BLOCK64K_WIPE, OP_WHOLE_ARRAY_WIPE: begin
        a.known = 1'b1;
        a.has_addr = (op != OP_WHOLE_ARRAY_WIPE);
        a.exec = 1'b1;
        a.array = 1'b1;
      end
      OP_WRITE_LATCH_SET, OP_WRITE_LATCH_CLEAR, OP_FLAG_STATUS_CLEAR: begin
        a.known = 1'b1;
        a.exec = 1'b1;
      end
      OP_STATUS_WRITE, OP_VOL_CONFIG_WRITE, OP_ENH_CONFIG_WRITE, OP_LOCK_WRITE,
      OP_NV_CONFIG_WRITE: begin
        a.known = 1'b1;
        a.has_addr = (op == OP_LOCK_WRITE);
        a.din = 1'b1;
        a.exec = 1'b1;
        a.cnt_min = (op == OP_NV_CONFIG_WRITE) ? NV_CONFIG_BYTES : REG_WRITE_BYTES;
        a.cnt_max = a.cnt_min;
      end
      OP_STATUS_FETCH, OP_FLAG_STATUS_FETCH, OP_VOL_CONFIG_FETCH, OP_ENH_CONFIG_FETCH,
      OP_LOCK_FETCH, OP_NV_CONFIG_FETCH, OP_MODIFY_PAUSE, OP_MODIFY_RESUME: begin
        a.known = 1'b1;
        a.has_addr = (op == OP_LOCK_FETCH);
        a.dout = (op != OP_MODIFY_PAUSE) && (op != OP_MODIFY_RESUME);
        a.cnt_max = (op == OP_NV_CONFIG_FETCH) ? NV_CONFIG_BYTES : 9'd0;
      end
      default: begin
      end
    endcase
    if (op == OP_OTP_FETCH || op == OP_OTP_WRITE) a.cnt_max = OTP_BYTES;
    if (op == OP_DUAL_IO_FETCH || op == OP_DUAL_IN_EXT_PAGE_WRITE) a.addr_lines = LINES_2;
    if (op == OP_QUAD_IO_FETCH || op == OP_QUAD_IN_EXT_PAGE_WRITE) a.addr_lines = LINES_4;
    if (op == OP_DUAL_OUT_FETCH || op == OP_DUAL_IO_FETCH || op == OP_DUAL_IN_PAGE_WRITE ||
        op == OP_DUAL_IN_EXT_PAGE_WRITE) a.data_lines = LINES_2;
    if (op == OP_QUAD_OUT_FETCH || op == OP_QUAD_IO_FETCH || op == OP_QUAD_IN_PAGE_WRITE ||
        op == OP_QUAD_IN_EXT_PAGE_WRITE) a.data_lines = LINES_4;
    if (op == OP_QUAD_IO_FETCH) a.dummy_def = DUMMY_QUAD_IO_DEFAULT;
    return a;
  endfunction

  typedef struct packed {
    sfcd_phase_t st;
    logic sclk_q;
    logic [7:0] op;
    sfcd_attr_t at;
    logic [23:0] sh;
    logic [23:0] addr;
    logic [4:0] cnt;
    logic [2:0] bitcnt;
    logic [8:0] nbytes;
    logic [7:0] wdata;
    logic wstb;
    logic exec;
    logic discard;
    logic susp;
    logic resm;
    logic rstart;
    logic rreq;
    logic [1:0] rpipe;
    logic [7:0] nxt;
    logic load;
    logic shift;
    logic stop;
  } sfcd_core_t;
  localparam sfcd_core_t CORE_RESET = '0;
endpackage

/* rtl/sfcd_sync.sv */
`timescale 1ns/1ps
module sfcd_sync (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // pins: sclk, select, four io lines
  input wire logic [5:0] i_async,
  output logic [5:0] o_sync
);
  sfcd_pkg::sfcd_sync_t q;
  sfcd_pkg::sfcd_sync_t d;

  always_comb begin
    d.m = i_async;
    d.s = q.m;
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      q <= sfcd_pkg::SYNC_RESET;
    end else begin
      q <= d;
    end
  end

  assign o_sync = q.s;
endmodule

/* rtl/sfcd_out_shift.sv */
`timescale 1ns/1ps
module sfcd_out_shift (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // control from the decoder
  input wire logic i_load,
  input wire logic i_shift,
  input wire logic i_stop,
  input wire logic [7:0] i_byte,
  input wire logic [2:0] i_lines,
  // io pins and status
  output logic [3:0] o_io_out,
  output logic [3:0] o_io_oe_n,
  output logic o_boundary
);
  sfcd_pkg::sfcd_shift_t q;
  sfcd_pkg::sfcd_shift_t d;
  logic [7:0] b;
  logic [2:0] ln;

  always_comb begin
    d = q;
    b = i_load ? i_byte : q.sr;
    ln = i_load ? i_lines : q.lines;
    if (i_stop) begin
      d.oe_n = 4'hF;
      d.left = 4'h0;
    end else if (i_load || (i_shift && q.left != 4'h0)) begin
      d.lines = ln;
      d.left = (i_load ? 4'h8 : q.left) - {1'b0, ln};
      case (ln)
        sfcd_pkg::LINES_4: begin
          d.dout = b[7:4];
          d.sr = {b[3:0], 4'h0};
          d.oe_n = 4'h0;
        end
        sfcd_pkg::LINES_2: begin
          d.dout = {2'b00, b[7:6]};
          d.sr = {b[5:0], 2'b00};
          d.oe_n = 4'hC;
        end
        default: begin
          d.dout = {2'b00, b[7], 1'b0};
          d.sr = {b[6:0], 1'b0};
          d.oe_n = 4'hD;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      q <= sfcd_pkg::SHIFT_RESET;
    end else begin
      q <= d;
    end
  end

  assign o_io_out = q.dout;
  assign o_io_oe_n = q.oe_n;
  assign o_boundary = (q.left == 4'h0);
endmodule

/* rtl/sfcd_decoder.sv */
`timescale 1ns/1ps
module sfcd_decoder (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // link pins from the host controller
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic [3:0] i_io_in,
  output logic [3:0] o_io_out,
  output logic [3:0] o_io_oe_n,
  // device state from the array controller
  input wire logic [3:0] i_dummy_cfg,
  input wire logic i_busy,
  input wire logic i_susp_ok,
  // decoded command
  output logic [7:0] o_cmd_op,
  output logic [23:0] o_cmd_addr,
  output logic o_exec,
  output logic o_discard,
  output logic o_suspend,
  output logic o_resume,
  // write data toward the array controller
  output logic [7:0] o_wr_data,
  output logic o_wr_stb,
  output logic [8:0] o_wr_count,
  // read data from the array controller
  output logic o_rd_start,
  output logic o_rd_req,
  input wire logic [7:0] i_rd_data
);
  sfcd_pkg::sfcd_core_t q;
  sfcd_pkg::sfcd_core_t n;
  sfcd_pkg::sfcd_attr_t at_new;
  logic [5:0] pins_s;
  logic sclk_s;
  logic cs_n_s;
  logic [3:0] io_s;
  logic serial_in_line;
  logic rise;
  logic fall;
  logic boundary;
  logic [2:0] lines;
  logic [4:0] last;
  logic [4:0] dummy_cnt;
  logic [23:0] sh_next;
  logic [7:0] op_new;
  logic exec_ok;

  // pins pass two flops before anything looks at them
  sfcd_sync u_sync (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_async({i_io_in, i_cs_n, i_sclk}),
    .o_sync(pins_s)
  );

  sfcd_out_shift u_out (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_load(n.load),
    .i_shift(n.shift),
    .i_stop(n.stop),
    .i_byte(q.nxt),
    .i_lines(q.at.data_lines),
    .o_io_out(o_io_out),
    .o_io_oe_n(o_io_oe_n),
    .o_boundary(boundary)
  );

  assign sclk_s = pins_s[sfcd_pkg::SYNC_SCLK];
  assign cs_n_s = pins_s[sfcd_pkg::SYNC_CS];
  assign io_s = pins_s[sfcd_pkg::SYNC_IO +: 4];
  assign serial_in_line = io_s[0];
  assign rise = sclk_s && !q.sclk_q;
  assign fall = !sclk_s && q.sclk_q;

  // lines in use for the current input phase
  always_comb begin
    lines = sfcd_pkg::LINES_1;
    if (q.st == sfcd_pkg::ST_ADDR) begin
      lines = q.at.addr_lines;
    end else if (q.st == sfcd_pkg::ST_DIN) begin
      lines = q.at.data_lines;
    end
    if (q.st == sfcd_pkg::ST_ADDR) begin
      last = sfcd_pkg::sfcd_last(sfcd_pkg::ADDR_BITS, lines);
    end else begin
      last = sfcd_pkg::sfcd_last(sfcd_pkg::BYTE_BITS, lines);
    end
  end

  // msb first: new bits enter at the bottom
  always_comb begin
    case (lines)
      sfcd_pkg::LINES_4: sh_next = {q.sh[19:0], io_s};
      sfcd_pkg::LINES_2: sh_next = {q.sh[21:0], io_s[1:0]};
      default: sh_next = {q.sh[22:0], serial_in_line};
    endcase
  end

  // dummy clock count for the command in hand
  always_comb begin
    if (q.at.dummy == sfcd_pkg::DMY_FIXED) begin
      dummy_cnt = sfcd_pkg::DUMMY_DISCOVERY;
    end else if (i_dummy_cfg == sfcd_pkg::DUMMY_CFG_USE_DEFAULT) begin
      dummy_cnt = q.at.dummy_def;
    end else begin
      dummy_cnt = {1'b0, i_dummy_cfg};
    end
  end

  // byte-aligned end of a command that may execute
  always_comb begin
    exec_ok = q.at.exec && (q.bitcnt == 3'd0) &&
              (q.st == sfcd_pkg::ST_DIN || q.st == sfcd_pkg::ST_HOLD) &&
              (q.nbytes >= q.at.cnt_min) && (q.nbytes <= q.at.cnt_max);
  end

  assign op_new = sh_next[7:0];
  assign at_new = sfcd_pkg::sfcd_attr(op_new);

  always_comb begin
    n = q;
    n.sclk_q = sclk_s;
    n.wstb = 1'b0;
    n.exec = 1'b0;
    n.discard = 1'b0;
    n.susp = 1'b0;
    n.resm = 1'b0;
    n.rstart = 1'b0;
    n.rreq = 1'b0;
    n.load = 1'b0;
    n.shift = 1'b0;
    n.stop = 1'b0;
    n.rpipe = {q.rpipe[0], q.rreq};
    if (q.rpipe[1]) begin
      n.nxt = i_rd_data;
    end
    if (cs_n_s) begin
      // select released: end the frame, execute or throw away
      if (q.st != sfcd_pkg::ST_IDLE) begin
        n.stop = 1'b1;
        if (q.at.exec) begin
          n.exec = exec_ok;
          n.discard = !exec_ok;
        end else if (q.st == sfcd_pkg::ST_IGNORE) begin
          n.discard = 1'b1;
        end else if (q.st == sfcd_pkg::ST_HOLD && q.op == sfcd_pkg::OP_MODIFY_PAUSE) begin
          n.susp = i_busy && i_susp_ok;
          n.discard = !(i_busy && i_susp_ok);
        end else if (q.st == sfcd_pkg::ST_HOLD && q.op == sfcd_pkg::OP_MODIFY_RESUME) begin
          n.resm = 1'b1;
        end
      end
      n.st = sfcd_pkg::ST_IDLE;
    end else if (q.st == sfcd_pkg::ST_IDLE) begin
      n.st = sfcd_pkg::ST_OPC;
      n.cnt = 5'd0;
      n.bitcnt = 3'd0;
      n.nbytes = 9'd0;
      n.op = 8'h00;
      n.at = '0;
    end else if (rise) begin
      n.bitcnt = q.bitcnt + 3'd1;
      n.cnt = q.cnt + 5'd1;
      n.sh = sh_next;
      case (q.st)
        sfcd_pkg::ST_OPC: begin
          if (q.cnt == last) begin
            n.op = op_new;
            n.at = at_new;
            n.cnt = 5'd0;
            if (!at_new.known) begin
              n.st = sfcd_pkg::ST_IGNORE;
            end else if (i_busy && at_new.array) begin
              n.st = sfcd_pkg::ST_IGNORE;
            end else if (at_new.has_addr) begin
              n.st = sfcd_pkg::ST_ADDR;
            end else if (at_new.din) begin
              n.st = sfcd_pkg::ST_DIN;
            end else if (at_new.dout) begin
              n.st = sfcd_pkg::ST_DOUT;
              n.rstart = 1'b1;
              n.rreq = 1'b1;
            end else begin
              n.st = sfcd_pkg::ST_HOLD;
            end
          end
        end
        sfcd_pkg::ST_ADDR: begin
          if (q.cnt == last) begin
            n.addr = sh_next;
            n.cnt = 5'd0;
            if (q.at.dummy != sfcd_pkg::DMY_NONE) begin
              n.st = sfcd_pkg::ST_DUMMY;
            end else if (q.at.din) begin
              n.st = sfcd_pkg::ST_DIN;
            end else if (q.at.dout) begin
              n.st = sfcd_pkg::ST_DOUT;
              n.rstart = 1'b1;
              n.rreq = 1'b1;
            end else begin
              n.st = sfcd_pkg::ST_HOLD;
            end
          end
        end
        sfcd_pkg::ST_DUMMY: begin
          if (q.cnt == dummy_cnt - 5'd1) begin
            n.st = sfcd_pkg::ST_DOUT;
            n.cnt = 5'd0;
            n.rstart = 1'b1;
            n.rreq = 1'b1;
          end
        end
        sfcd_pkg::ST_DIN: begin
          if (q.cnt == last) begin
            n.cnt = 5'd0;
            n.wdata = sh_next[7:0];
            n.wstb = (q.nbytes < q.at.cnt_max);
            if (q.nbytes != sfcd_pkg::COUNT_SAT) begin
              n.nbytes = q.nbytes + 9'd1;
            end
          end
        end
        default: begin
        end
      endcase
    end else if (fall && q.st == sfcd_pkg::ST_DOUT) begin
      if (!boundary) begin
        n.shift = 1'b1;
      end else if (q.at.cnt_max != 9'd0 && q.nbytes == q.at.cnt_max) begin
        n.stop = 1'b1;
        n.st = sfcd_pkg::ST_HOLD;
      end else begin
        n.load = 1'b1;
        n.rreq = 1'b1;
        if (q.nbytes != sfcd_pkg::COUNT_SAT) begin
          n.nbytes = q.nbytes + 9'd1;
        end
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      q <= sfcd_pkg::CORE_RESET;
    end else begin
      q <= n;
    end
  end

  assign o_cmd_op = q.op;
  assign o_cmd_addr = q.addr;
  assign o_exec = q.exec;
  assign o_discard = q.discard;
  assign o_suspend = q.susp;
  assign o_resume = q.resm;
  assign o_wr_data = q.wdata;
  assign o_wr_stb = q.wstb;
  assign o_wr_count = q.nbytes;
  assign o_rd_start = q.rstart;
  assign o_rd_req = q.rreq;
endmodule

/* verif/sfcd_decoder_asserts.sv */
`timescale 1ns/1ps
module sfcd_decoder_asserts (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // observed ports
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_busy,
  input wire logic i_susp_ok,
  input wire logic [3:0] o_io_out,
  input wire logic [3:0] o_io_oe_n,
  input wire logic [7:0] o_cmd_op,
  input wire logic o_exec,
  input wire logic o_discard,
  input wire logic o_suspend,
  input wire logic o_resume,
  input wire logic o_rd_start,
  input wire logic [8:0] o_wr_count
);
  logic [3:0] hi_q;
  // cycles since select went high, saturating
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) hi_q <= 4'h0;
    else if (!i_cs_n) hi_q <= 4'h0;
    else if (hi_q != 4'hF) hi_q <= hi_q + 4'h1;
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  AST_ONE_VERDICT: assert property (o_exec |-> !o_discard && $past(i_cs_n, 2) && i_cs_n)
    else $error("exec without select high or with discard");
  AST_EXEC_PULSE: assert property (o_exec |=> !o_exec && !o_discard)
    else $error("exec not a single pulse");
  AST_OUT_RELEASED: assert property (hi_q >= 4'h8 |-> o_io_oe_n == 4'hF)
    else $error("output still driven after deselect");
  AST_BUSY_BLOCKS: assert property (o_rd_start && i_busy |->
    o_cmd_op inside {8'h05, 8'h70, 8'h85, 8'h65, 8'hE8, 8'hB5})
    else $error("array fetch started while busy");
  AST_BUSY_NO_MODIFY: assert property (o_exec && i_busy |->
    !(o_cmd_op inside {8'h02, 8'h20, 8'hD8, 8'hC7}))
    else $error("modify accepted while busy");
  AST_PAUSE_GATED: assert property (o_suspend |-> i_busy && i_susp_ok && o_cmd_op == 8'h75)
    else $error("pause without a pausable cycle");
  AST_RESUME_OP: assert property (o_resume |-> o_cmd_op == 8'h7A && !o_suspend)
    else $error("resume on wrong opcode");
  AST_LATCH_NO_DATA: assert property (o_exec && o_cmd_op inside {8'h04, 8'h06} |->
    o_wr_count == 9'h000)
    else $error("latch command carried data");
  AST_PAGE_COUNT: assert property (o_exec && o_cmd_op == 8'h02 |->
    o_wr_count inside {[9'h001:9'h100]})
    else $error("page write count out of range");
  AST_OUT_ON_FALL: assert property ($changed(o_io_out) && !o_io_oe_n[1] && $past(!o_io_oe_n[1])
    |-> !$past(i_sclk, 3))
    else $error("output changed away from a falling clock");
endmodule
bind sfcd_decoder sfcd_decoder_asserts u_chk (.i_core_clk, .i_rst, .i_sclk, .i_cs_n, .i_busy,
  .i_susp_ok, .o_io_out, .o_io_oe_n, .o_cmd_op, .o_exec, .o_discard, .o_suspend, .o_resume,
  .o_rd_start, .o_wr_count);

/* verif/sfcd_host.sv */
`timescale 1ns/1ps
module sfcd_host (
  // line values from the device
  input wire logic [3:0] i_io_out,
  input wire logic [3:0] i_io_oe_n,
  // link pins toward the device
  output logic o_sclk = 1'b0,
  output logic o_cs_n = 1'b1,
  output logic [3:0] o_io = 4'hF
);
  logic so_last = 1'b0;
  // select low, then a settling gap before the first rise
  task automatic sel();
    o_cs_n = 1'b0;
    // the quarter step keeps link edges off core clock edges
    #40.25;
  endtask
  task automatic bit_x(input logic b, output logic r);
    o_io[0] = b;
    #62.5;
    o_sclk = 1'b1;
    // a released line shows the inverse of its last value
    r = i_io_oe_n[1] ? !so_last : i_io_out[1];
    so_last = r;
    #62.5;
    o_sclk = 1'b0;
  endtask
  task automatic byte_x(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
  endtask
  // clock stays low between frames
  task automatic desel();
    #30;
    o_cs_n = 1'b1;
    o_io[0] = !o_io[0];
    #300;
  endtask
endmodule

/* verif/tb.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
module tb;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_busy = 1'b0;
  logic i_susp_ok = 1'b0;
  logic [3:0] i_dummy_cfg = 4'h0;
  logic [7:0] i_rd_data = 8'h00;
  logic [7:0] idx = 8'h00;
  logic [7:0] last_wr = 8'h00;
  logic i_sclk, i_cs_n, o_exec, o_discard, o_suspend, o_resume, o_wr_stb, o_rd_start, o_rd_req;
  logic [3:0] i_io_in, io_h, o_io_out, o_io_oe_n;
  logic [7:0] o_cmd_op, o_wr_data;
  logic [23:0] o_cmd_addr;
  logic [8:0] o_wr_count;
  logic [7:0] rxb [0:20];
  int n_mismatch = 0;
  int n_checks = 0;
  integer n_exec, n_disc, n_susp, n_res, n_wr, n_rds;
  always #4 i_core_clk = !i_core_clk;
  assign i_io_in = (o_io_out & ~o_io_oe_n) | (io_h & o_io_oe_n);
  sfcd_host h (.i_io_out(o_io_out), .i_io_oe_n(o_io_oe_n), .o_sclk(i_sclk), .o_cs_n(i_cs_n),
    .o_io(io_h));
  sfcd_decoder dut (.i_core_clk, .i_rst, .i_sclk, .i_cs_n, .i_io_in, .o_io_out, .o_io_oe_n,
    .i_dummy_cfg, .i_busy, .i_susp_ok, .o_cmd_op, .o_cmd_addr, .o_exec, .o_discard, .o_suspend,
    .o_resume, .o_wr_data, .o_wr_stb, .o_wr_count, .o_rd_start, .o_rd_req, .i_rd_data);
  // array side: each fetch returns C3h, C4h, ...
  always @(posedge i_core_clk) begin
    if (o_rd_start) begin
      i_rd_data <= 8'hC3;
      idx <= 8'h01;
    end else if (o_rd_req) begin
      i_rd_data <= 8'hC3 + idx;
      idx <= idx + 8'h01;
    end
    if (o_wr_stb) last_wr <= o_wr_data;
    n_exec += o_exec;
    n_disc += o_discard;
    n_susp += o_suspend;
    n_res += o_resume;
    n_wr += o_wr_stb;
    n_rds += o_rd_start;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic do_reset();
    @(posedge i_core_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    i_rst <= 1'b0;
    repeat (3) @(posedge i_core_clk);
  endtask
  task automatic dev(input logic b, input logic s, input logic [3:0] d);
    @(posedge i_core_clk);
    i_busy <= b;
    i_susp_ok <= s;
    i_dummy_cfg <= d;
    @(posedge i_core_clk);
  endtask
  // one frame: opcode, address bytes, dummy clocks, data bytes, stray bits
  task automatic cmd(input logic [7:0] op, input int na, input int nd, input int nb, input int xb);
    logic r;
    {n_exec, n_disc, n_susp, n_res, n_wr, n_rds} = '0;
    @(negedge i_core_clk);
    h.sel();
    h.byte_x(op, rxb[0]);
    for (int i = 0; i < na; i++) h.byte_x(8'h10 + 8'(i), rxb[0]);
    for (int i = 0; i < nd; i++) h.bit_x(1'b0, r);
    for (int i = 0; i < nb; i++) h.byte_x(8'h3C + 8'(i), rxb[i]);
    for (int i = 0; i < xb; i++) h.bit_x(1'b1, r);
    h.desel();
  endtask
  task automatic t_regs();
    logic [7:0] ops [8] = '{8'h06, 8'h04, 8'h50, 8'h01, 8'h81, 8'h61, 8'hE5, 8'hB1};
    int nbs [8] = '{0, 0, 0, 1, 1, 1, 1, 2};
    for (int i = 0; i < 8; i++) begin
      cmd(ops[i], (ops[i] == 8'hE5) ? 3 : 0, 0, nbs[i], 0);
      `CHK("exec", 1, n_exec)
      `CHK("wr bytes", nbs[i], n_wr)
      `CHK("op", ops[i], o_cmd_op)
      cmd(ops[i], (ops[i] == 8'hE5) ? 3 : 0, 0, nbs[i], 1);
      `CHK("cut", 1, n_disc)
    end
    cmd(8'h01, 0, 0, 2, 0);
    `CHK("long write", 1, n_disc)
    $display("test regs done");
  endtask
  task automatic t_read();
    cmd(8'h03, 3, 0, 2, 3);
    `CHK("addr", 24'h101112, o_cmd_addr)
    `CHK("byte0", 8'hC3, rxb[0])
    `CHK("byte1", 8'hC4, rxb[1])
    `CHK("release", 4'hF, o_io_oe_n)
    $display("test read done");
  endtask
  task automatic t_dummy();
    logic [7:0] ops [5] = '{8'h0B, 8'h0B, 8'h5A, 8'h4B, 8'h6B};
    logic [3:0] cfg [5] = '{4'h0, 4'h3, 4'h3, 4'h0, 4'h0};
    int nd [5] = '{8, 3, 8, 8, 8};
    // four-line data: line 1 carries bits 5 and 1 of C3h..C6h
    logic [7:0] ex [5] = '{8'hC3, 8'hC3, 8'hC3, 8'hC3, 8'h41};
    for (int i = 0; i < 5; i++) begin
      dev(1'b0, 1'b0, cfg[i]);
      cmd(ops[i], 3, nd[i], 1, 0);
      `CHK("dummy fetch", ex[i], rxb[0])
    end
    $display("test dummy done");
  endtask
  task automatic t_ident();
    @(negedge i_core_clk);
    h.sel();
    h.byte_x(8'h9E, rxb[0]);
    for (int i = 0; i < 20; i++) h.byte_x(8'h00, rxb[i]);
    #60;
    `CHK("id last", 8'hD6, rxb[19])
    `CHK("id stop", 1'b1, o_io_oe_n[1])
    h.desel();
    cmd(8'h9F, 0, 0, 1, 0);
    `CHK("id alt", 8'hC3, rxb[0])
    $display("test ident done");
  endtask
  task automatic t_page();
    cmd(8'h02, 3, 0, 2, 0);
    `CHK("page exec", 1, n_exec)
    `CHK("page strobes", 2, n_wr)
    `CHK("page data", 8'h3D, last_wr)
    `CHK("page count", 9'h002, o_wr_count)
    cmd(8'h02, 3, 0, 0, 0);
    `CHK("empty page", 1, n_disc)
    cmd(8'h20, 3, 0, 0, 0);
    `CHK("wipe", 1, n_exec)
    cmd(8'hC7, 0, 0, 0, 0);
    `CHK("whole wipe", 1, n_exec)
    $display("test page done");
  endtask
  task automatic t_busy();
    dev(1'b1, 1'b1, 4'h0);
    cmd(8'h03, 3, 0, 1, 0);
    `CHK("busy fetch", 0, n_rds)
    `CHK("busy refuse", 1, n_disc)
    cmd(8'h05, 0, 0, 1, 0);
    `CHK("poll status", 8'hC3, rxb[0])
    cmd(8'h70, 0, 0, 1, 0);
    `CHK("poll flags", 8'hC3, rxb[0])
    cmd(8'hD8, 3, 0, 0, 0);
    `CHK("busy wipe", 0, n_exec)
    cmd(8'h06, 0, 0, 0, 0);
    `CHK("busy latch", 1, n_exec)
    cmd(8'h75, 0, 0, 0, 0);
    `CHK("pause", 1, n_susp)
    dev(1'b1, 1'b0, 4'h0);
    cmd(8'h75, 0, 0, 0, 0);
    `CHK("pause refused", 1, n_disc)
    cmd(8'h7A, 0, 0, 0, 0);
    `CHK("resume", 1, n_res)
    dev(1'b0, 1'b0, 4'h0);
    $display("test busy done");
  endtask
  task automatic t_unknown();
    cmd(8'hFF, 0, 0, 2, 0);
    `CHK("unknown", 1, n_disc)
    `CHK("unknown exec", 0, n_exec + n_rds)
    do_reset();
    cmd(8'h06, 0, 0, 0, 0);
    `CHK("after reset", 1, n_exec)
    $display("test unknown done");
  endtask
  initial begin
    do_reset();
    t_regs();
    t_read();
    t_dummy();
    t_ident();
    t_page();
    t_busy();
    t_unknown();
    wrap_up();
  end
  initial begin
    repeat (80000) @(posedge i_core_clk);
    n_mismatch++;
    wrap_up();
  end
endmodule
